// ### logic/cac_alert_config.sv
// Charger option and throttle-alert option registers with alert generation
//
// Function
// - High-impedance enable bit enters low-power mode
// - Defaults-reset bit restores registers, then self-clears
// - Remeasure bit stops converter until measurement done
// - Optimizer enable bit switches current optimizer
// - Battery switch off in high-impedance when set
// - Codes 1..25 map 110..230 percent, 5 steps
// - Codes 26..30 map 250..450 percent; 31 ignored
// - Overcurrent level resets to code 01001
// - Critical threshold is 110 percent of level
// - Critical filter selects 15/100/400/800 us
// - Undervoltage qualified by fixed 20 us filter
// - Undervoltage level selects per-cell-count thresholds
// - Stretch holds alert low until clear written
// - Pulse width selects minimum alert low time
// - Registers reset to 0000h and 4A54h
// - Writing clear 0 ends pulse; 1 idles
`timescale 1ns/1ps
module cac_alert_config
	import cac_pkg::*;
#(
	parameter int CYC_CRIT_0 = CYC_CRIT_00, // Critical filter, code 00
	parameter int CYC_CRIT_1 = CYC_CRIT_01, // Critical filter, code 01
	parameter int CYC_CRIT_2 = CYC_CRIT_10, // Critical filter, code 10
	parameter int CYC_CRIT_3 = CYC_CRIT_11, // Critical filter, code 11
	parameter int CYC_PW_0   = CYC_PW_00,   // Pulse width, code 00
	parameter int CYC_PW_1   = CYC_PW_01,   // Pulse width, code 01
	parameter int CYC_PW_2   = CYC_PW_10,   // Pulse width, code 10
	parameter int CYC_PW_3   = CYC_PW_11    // Pulse width, code 11
)(
	input  wire logic        i_mclk,           // Core clock, 200 MHz
	input  wire logic        i_reset_n,        // Async reset, active low
	input  wire logic        i_clk_en,         // Freezes state when low
	input  wire logic        i_wr_en,          // Register write strobe
	input  wire logic        i_rd_en,          // Register read strobe
	input  wire logic [7:0]  i_cmd,            // Register command code
	input  wire logic [15:0] i_wr_data,        // Write word
	output logic      [15:0] o_rd_data,        // Read word, registered
	input  wire logic        i_vin_meas_done,  // Input limit measurement done
	input  wire cac_sense_t  i_sense,          // Measured current and voltage
	output cac_ctrl_t        o_ctrl,           // Mode controls
	output logic             o_throttle_alert_n // Throttle alert, active low
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic [8:0] oc2_pct(input logic [4:0] code);
		logic [8:0] pct;
		pct = 9'h000;
		if (code == 5'h00 || code == OC2_OUT_RANGE) begin
			pct = 9'h000;
		end else if (code <= OC2_LIN_LAST) begin
			pct = 9'(OC2_LIN_OFFSET_PCT + OC2_LIN_STEP_PCT * int'(code));
		end else begin
			pct = 9'(OC2_HI_BASE_PCT + OC2_HI_STEP_PCT * int'(code - OC2_STEP_BASE));
		end
		return pct;
	endfunction

	function automatic logic [CNT_W-1:0] sel4(input logic [1:0] code, input int c0,
		input int c1, input int c2, input int c3);
		logic [CNT_W-1:0] r;
		r = CNT_W'(c0);
		case (code)
			2'b00: r = CNT_W'(c0);
			2'b01: r = CNT_W'(c1);
			2'b10: r = CNT_W'(c2);
			default: r = CNT_W'(c3);
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	cac_state_t st_r;
	cac_state_t st_nxt;

	logic [15:0]      opt_c;
	logic [15:0]      opt_a;
	logic [4:0]       oc2_code;
	logic [8:0]       oc2_level;
	logic [31:0]      meas_scaled;
	logic [31:0]      crit_scaled;
	logic             crit_raw;
	logic             crit_ok;
	logic [15:0]      uv_mv;
	logic             uv_raw;
	logic             uv_ok;
	logic             trigger;
	logic [CNT_W-1:0] crit_cycles;
	logic [CNT_W-1:0] pulse_cycles;
	logic             wr_c;
	logic             wr_a;
	logic             clr_write;

	assign opt_c = st_r.charger_option_reg_c;
	assign opt_a = st_r.throttle_alert_option_a;

	// ------------------------------------------------------------
	// Trigger conditions
	// ------------------------------------------------------------
	assign oc2_code  = opt_a[POS_OC2_LSB +: 5];
	assign oc2_level = oc2_pct(oc2_code);

	// Current x 1000 against limit x level x 11: critical at 110% of level
	assign meas_scaled = 32'(i_sense.input_current) * 32'd1000;
	assign crit_scaled = 32'(i_sense.current_limit) * 32'(oc2_level) * 32'(CRIT_PCT / 10);
	assign crit_raw    = (oc2_level != 9'h000) && (meas_scaled > crit_scaled);

	assign crit_cycles = sel4(opt_a[POS_CRIT_FLT_LSB +: 2],
		CYC_CRIT_0, CYC_CRIT_1, CYC_CRIT_2, CYC_CRIT_3);

	cac_deglitch u_crit_filter (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_clk_en    (i_clk_en),
		.i_level     (crit_raw),
		.i_count     (crit_cycles),
		.o_qualified (crit_ok)
	);

	always_comb begin
		uv_mv = UV_MULTI_MV_1;
		case (opt_a[POS_UV_LVL_LSB +: 2])
			2'b00: uv_mv = i_sense.one_cell ? UV_ONE_MV_0 : UV_MULTI_MV_0;
			2'b01: uv_mv = i_sense.one_cell ? UV_ONE_MV_1 : UV_MULTI_MV_1;
			2'b10: uv_mv = i_sense.one_cell ? UV_ONE_MV_2 : UV_MULTI_MV_2;
			default: uv_mv = i_sense.one_cell ? UV_ONE_MV_3 : UV_MULTI_MV_3;
		endcase
	end

	assign uv_raw = i_sense.system_mv < uv_mv;

	cac_deglitch u_uv_filter (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_clk_en    (i_clk_en),
		.i_level     (uv_raw),
		.i_count     (CNT_W'(CYC_UV)),
		.o_qualified (uv_ok)
	);

	assign trigger = crit_ok | uv_ok;

	assign pulse_cycles = sel4(opt_a[POS_PW_LSB +: 2],
		CYC_PW_0, CYC_PW_1, CYC_PW_2, CYC_PW_3);

	// ------------------------------------------------------------
	// Register writes and alert sequencing
	// ------------------------------------------------------------
	assign wr_c      = i_wr_en && (i_cmd == ADDR_CHARGER_OPTION_C);
	assign wr_a      = i_wr_en && (i_cmd == ADDR_ALERT_OPTION_A);
	assign clr_write = wr_a && !i_wr_data[POS_PULSE_CLR];

	always_comb begin
		st_nxt = st_r;

		// Whole words stored, reserved bits included
		if (wr_c) begin
			st_nxt.charger_option_reg_c = i_wr_data;
		end else if (wr_a) begin
			st_nxt.throttle_alert_option_a = i_wr_data;
		end

		// Measurement finished: bit drops, converter restarts unless high impedance is enabled
		if (st_r.charger_option_reg_c[POS_VIN_REMEAS] && i_vin_meas_done && !wr_c) begin
			st_nxt.charger_option_reg_c[POS_VIN_REMEAS] = 1'b0;
		end

		// Clear is a command; the bit returns to idle
		if (clr_write) begin
			st_nxt.throttle_alert_option_a[POS_PULSE_CLR] = 1'b1;
		end

		case (st_r.alert_st)
			ALERT_IDLE: begin
				if (trigger) begin
					st_nxt.width_cnt = '0;
					st_nxt.alert_st  = opt_a[POS_STRETCH_EN] ? ALERT_STRETCH : ALERT_TIMED;
				end
			end
			ALERT_TIMED: begin
				if (clr_write) begin
					st_nxt.alert_st = ALERT_IDLE;
				end else if (st_r.width_cnt + CNT_W'(1) < pulse_cycles) begin
					st_nxt.width_cnt = st_r.width_cnt + CNT_W'(1);
				end else if (!trigger) begin
					st_nxt.alert_st = ALERT_IDLE;
				end
			end
			ALERT_STRETCH: begin
				if (clr_write) begin
					st_nxt.alert_st = ALERT_IDLE;
				end
			end
			default: begin
				st_nxt.alert_st = ALERT_IDLE;
			end
		endcase

		// Read data
		if (i_rd_en) begin
			if (i_cmd == ADDR_CHARGER_OPTION_C) begin
				st_nxt.rd_data = st_r.charger_option_reg_c;
			end else if (i_cmd == ADDR_ALERT_OPTION_A) begin
				st_nxt.rd_data = st_r.throttle_alert_option_a;
			end else begin
				st_nxt.rd_data = 16'h0000;
			end
		end

		// Defaults reset: both words back to reset values, bit self-clears
		if (wr_c && i_wr_data[POS_DEFAULTS_RST]) begin
			st_nxt.charger_option_reg_c    = RST_CHARGER_OPTION_C;
			st_nxt.throttle_alert_option_a = RST_ALERT_OPTION_A;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r.charger_option_reg_c    <= RST_CHARGER_OPTION_C;
			st_r.throttle_alert_option_a <= RST_ALERT_OPTION_A;
			st_r.rd_data                 <= 16'h0000;
			st_r.alert_st                <= ALERT_IDLE;
			st_r.width_cnt               <= '0;
		end else if (i_clk_en) begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_rd_data                = st_r.rd_data;
	assign o_ctrl.high_impedance    = opt_c[POS_HIGHZ_EN];
	assign o_ctrl.battery_switch_on = !(opt_c[POS_HIGHZ_EN] && opt_c[POS_BAT_OFF_HIZ]);
	assign o_ctrl.optimizer_enable  = opt_c[POS_OPT_EN];
	assign o_ctrl.converter_enable  = !opt_c[POS_VIN_REMEAS] && !opt_c[POS_HIGHZ_EN];
	assign o_ctrl.defaults_reset    = wr_c && i_wr_data[POS_DEFAULTS_RST];
	assign o_throttle_alert_n       = (st_r.alert_st == ALERT_IDLE);

endmodule

// ### logic/cac_pkg.sv
// Package: offsets, fields, reset values and timing for the alert config block
package cac_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ          = 200;
	localparam int T_CRIT_00_US     = 15;
	localparam int T_CRIT_01_US     = 100;
	localparam int T_CRIT_10_US     = 400;
	localparam int T_CRIT_11_US     = 800;
	localparam int T_UV_US          = 20;
	localparam int T_PW_00_US       = 100;
	localparam int T_PW_01_MS       = 1;
	localparam int T_PW_10_MS       = 10;
	localparam int T_PW_11_MS       = 5;
	localparam int CYC_CRIT_00      = T_CRIT_00_US * CLK_MHZ;
	localparam int CYC_CRIT_01      = T_CRIT_01_US * CLK_MHZ;
	localparam int CYC_CRIT_10      = T_CRIT_10_US * CLK_MHZ;
	localparam int CYC_CRIT_11      = T_CRIT_11_US * CLK_MHZ;
	localparam int CYC_UV           = T_UV_US * CLK_MHZ;
	localparam int CYC_PW_00        = T_PW_00_US * CLK_MHZ;
	localparam int CYC_PW_01        = T_PW_01_MS * 1000 * CLK_MHZ;
	localparam int CYC_PW_10        = T_PW_10_MS * 1000 * CLK_MHZ;
	localparam int CYC_PW_11        = T_PW_11_MS * 1000 * CLK_MHZ;
	localparam int CNT_W            = 22;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0]  ADDR_CHARGER_OPTION_C = 8'h32;
	localparam logic [7:0]  ADDR_ALERT_OPTION_A   = 8'h33;
	localparam logic [15:0] RST_CHARGER_OPTION_C  = 16'h0000;
	localparam logic [15:0] RST_ALERT_OPTION_A    = 16'h4A54;

	// Charger option fields
	localparam int POS_HIGHZ_EN     = 15;
	localparam int POS_DEFAULTS_RST = 14;
	localparam int POS_VIN_REMEAS   = 13;
	localparam int POS_OPT_EN       = 11;
	localparam int POS_BAT_OFF_HIZ  = 1;

	// Alert option fields
	localparam int POS_OC2_LSB      = 11;
	localparam int POS_CRIT_FLT_LSB = 9;
	localparam int POS_UV_LVL_LSB   = 6;
	localparam int POS_STRETCH_EN   = 5;
	localparam int POS_PW_LSB       = 3;
	localparam int POS_PULSE_CLR    = 2;

	// Overcurrent code map
	localparam logic [4:0] OC2_LIN_LAST  = 5'h19;
	localparam logic [4:0] OC2_STEP_BASE = 5'h1A;
	localparam logic [4:0] OC2_OUT_RANGE = 5'h1F;
	localparam int OC2_LIN_OFFSET_PCT    = 105;
	localparam int OC2_LIN_STEP_PCT      = 5;
	localparam int OC2_HI_BASE_PCT       = 250;
	localparam int OC2_HI_STEP_PCT       = 50;
	localparam int CRIT_PCT              = 110;

	// Undervoltage thresholds, millivolts
	localparam logic [15:0] UV_MULTI_MV_0 = 16'h1676;
	localparam logic [15:0] UV_MULTI_MV_1 = 16'h1770;
	localparam logic [15:0] UV_MULTI_MV_2 = 16'h186A;
	localparam logic [15:0] UV_MULTI_MV_3 = 16'h1964;
	localparam logic [15:0] UV_ONE_MV_0   = 16'h0B22;
	localparam logic [15:0] UV_ONE_MV_1   = 16'h0C1C;
	localparam logic [15:0] UV_ONE_MV_2   = 16'h0D16;
	localparam logic [15:0] UV_ONE_MV_3   = 16'h0E10;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ALERT_IDLE    = 2'b00,
		ALERT_TIMED   = 2'b01,
		ALERT_STRETCH = 2'b10
	} cac_alert_st_t;

	typedef struct packed {
		logic [15:0] charger_option_reg_c;
		logic [15:0] throttle_alert_option_a;
		logic [15:0] rd_data;
		cac_alert_st_t     alert_st;
		logic [CNT_W-1:0]  width_cnt;
	} cac_state_t;

	typedef struct packed {
		logic [15:0] input_current;
		logic [15:0] current_limit;
		logic [15:0] system_mv;
		logic        one_cell;
	} cac_sense_t;

	typedef struct packed {
		logic high_impedance;
		logic battery_switch_on;
		logic optimizer_enable;
		logic converter_enable;
		logic defaults_reset;
	} cac_ctrl_t;

	typedef struct packed {
		logic             active;
		logic [CNT_W-1:0] cnt;
	} cac_dg_state_t;

endpackage

// ### logic/cac_deglitch.sv
// Deglitch filter: output rises after input has been high for a set count
`timescale 1ns/1ps
module cac_deglitch
	import cac_pkg::*;
(
	input  wire logic             i_mclk,     // Core clock
	input  wire logic             i_reset_n,  // Async reset, active low
	input  wire logic             i_clk_en,   // Freezes state when low
	input  wire logic             i_level,    // Raw condition
	input  wire logic [CNT_W-1:0] i_count,    // Cycles to qualify
	output logic                  o_qualified // Deglitched condition
);

	cac_dg_state_t st_r;
	cac_dg_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (!i_level) begin
			st_nxt.cnt    = '0;
			st_nxt.active = 1'b0;
		end else if (st_r.cnt + CNT_W'(1) >= i_count) begin
			st_nxt.active = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r <= '0;
		end else if (i_clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign o_qualified = st_r.active;

endmodule

// ### dv/cac_sense_model.sv
// Partner model: sense values and input-limit measurement source
`timescale 1ns/1ps
module cac_sense_model
	import cac_pkg::*;
#(
	parameter int MEAS_CYC = 12 // Measurement time in cycles
)(
	input  wire logic        i_mclk,    // Clock
	input  wire logic        i_reset_n, // Reset, active low
	input  wire logic        i_conv_en, // Converter enable from block
	input  wire logic [15:0] i_cur,     // Input current to present
	input  wire logic [15:0] i_mv,      // System voltage, mV
	input  wire logic        i_one,     // One-cell pack
	output cac_sense_t       o_sense,   // Sense bundle
	output logic             o_done     // Measurement done
);
	int cnt;
	assign o_sense = {i_cur, 16'h03E8, i_mv, i_one};
	// Done only once the converter has been off for the measurement time
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			cnt <= 0;
		else
			cnt <= i_conv_en ? 0 : cnt + 1;
	end
	assign o_done = (cnt >= MEAS_CYC);
endmodule

// ### dv/cac_alert_config_checker.sv
// Checker: register, control and alert relations at the block ports
`timescale 1ns/1ps
module cac_alert_config_checker
	import cac_pkg::*;
#(
	parameter int CYC_PW_0 = CYC_PW_00 // Shortest pulse width
)(
	input wire logic        i_mclk,            // Clock
	input wire logic        i_reset_n,         // Reset, active low
	input wire logic        i_clk_en,          // Run enable
	input wire logic        i_wr_en,           // Write strobe
	input wire logic        i_rd_en,           // Read strobe
	input wire logic [7:0]  i_cmd,             // Command code
	input wire logic [15:0] i_wr_data,         // Write word
	input wire logic [15:0] o_rd_data,         // Read word
	input wire logic        i_vin_meas_done,   // Measurement done
	input wire cac_sense_t  i_sense,           // Sense bundle
	input wire cac_ctrl_t   o_ctrl,            // Mode controls
	input wire logic        o_throttle_alert_n // Alert, active low
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	logic             clr_w;
	logic [CNT_W-1:0] low_cnt_r;
	assign clr_w = i_clk_en && i_wr_en && i_cmd == 8'h33 && !i_wr_data[2];
	// Length of the current low pulse
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			low_cnt_r <= '0;
		else if (o_throttle_alert_n)
			low_cnt_r <= '0;
		else if (i_clk_en)
			low_cnt_r <= low_cnt_r + 1'b1;
	end
	sequence wr32_s;
		i_clk_en && i_wr_en && i_cmd == 8'h32 && !i_wr_data[14];
	endsequence
	sequence dflt_wr_s;
		i_clk_en && i_wr_en && i_cmd == 8'h32 && i_wr_data[14];
	endsequence
	sequence dflt_done_s;
		!o_ctrl.high_impedance && !o_ctrl.optimizer_enable && o_ctrl.converter_enable;
	endsequence
	highz_a: assert property (wr32_s |=> o_ctrl.high_impedance == $past(i_wr_data[15]))
		else $error("high impedance mode does not follow write");
	batsw_a: assert property (!o_ctrl.high_impedance |-> o_ctrl.battery_switch_on)
		else $error("battery switch off outside high impedance");
	opt_a: assert property (wr32_s |=> o_ctrl.optimizer_enable == $past(i_wr_data[11]))
		else $error("optimizer enable does not follow write");
	dflt_a: assert property (dflt_wr_s |-> o_ctrl.defaults_reset ##1 dflt_done_s)
		else $error("defaults reset did not restore controls");
	remeas_a: assert property (wr32_s ##0 i_wr_data[13] |=> !o_ctrl.converter_enable)
		else $error("converter not stopped for measurement");
	meas_done_a: assert property (!o_ctrl.converter_enable && !o_ctrl.high_impedance
		&& i_clk_en && i_vin_meas_done && !i_wr_en |=> o_ctrl.converter_enable)
		else $error("converter not restarted after measurement");
	clr_end_a: assert property (clr_w && !o_throttle_alert_n |=> o_throttle_alert_n)
		else $error("clear write did not end alert pulse");
	clr_read_a: assert property (i_clk_en && i_rd_en && i_cmd == 8'h33 |=> o_rd_data[2])
		else $error("pulse clear bit does not read back one");
	pw_min_a: assert property ($rose(o_throttle_alert_n) && !$past(clr_w)
		&& !$past(o_ctrl.defaults_reset) |-> int'(low_cnt_r) >= CYC_PW_0 - 1)
		else $error("alert pulse shorter than minimum width");
endmodule
bind cac_alert_config cac_alert_config_checker #(.CYC_PW_0(CYC_PW_0)) cac_alert_config_checker_inst (
	.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_wr_en(i_wr_en),
	.i_rd_en(i_rd_en), .i_cmd(i_cmd), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
	.i_vin_meas_done(i_vin_meas_done), .i_sense(i_sense), .o_ctrl(o_ctrl),
	.o_throttle_alert_n(o_throttle_alert_n));

// ### dv/tb.sv
// Testbench: registers, controls and alert timing of the alert config block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
	$display("[FAIL] %s exp %h got %h", nm, e, s); end end
module tb;
	import cac_pkg::*;
	logic        i_mclk = 1'b0, i_reset_n = 1'b0, i_clk_en = 1'b1;
	logic        i_wr_en = 1'b0, i_rd_en = 1'b0, one = 1'b0, rd_seen = 1'b0;
	logic [7:0]  i_cmd = 8'h00;
	logic [15:0] i_wr_data = 16'h0000, cur = 16'h0000, mv = 16'h2000, d, mon_e;
	logic [15:0] o_rd_data;
	logic        i_vin_meas_done, o_throttle_alert_n;
	cac_sense_t  i_sense;
	cac_ctrl_t   o_ctrl;
	int          fails = 0, checked = 0, seed = 92468, p, thr;
	int          codes[4] = '{1, 25, 26, 30};
	logic [15:0] exp_q[$];
	string       nm_q[$], mon_n;
	always #2.5 i_mclk = ~i_mclk;
	cac_alert_config #(.CYC_CRIT_0(3), .CYC_PW_0(20), .CYC_PW_1(40), .CYC_PW_2(80),
		.CYC_PW_3(60)) cac_alert_config_inst (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_wr_en(i_wr_en),
		.i_rd_en(i_rd_en), .i_cmd(i_cmd), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
		.i_vin_meas_done(i_vin_meas_done), .i_sense(i_sense), .o_ctrl(o_ctrl),
		.o_throttle_alert_n(o_throttle_alert_n));
	cac_sense_model cac_sense_model_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_conv_en(o_ctrl.converter_enable), .i_cur(cur), .i_mv(mv), .i_one(one),
		.o_sense(i_sense), .o_done(i_vin_meas_done));
	// Read results checked against the oldest note
	always @(posedge i_mclk) rd_seen <= i_rd_en && i_clk_en && i_reset_n;
	always @(negedge i_mclk) begin
		if (rd_seen) begin
			mon_n = nm_q.pop_front();
			mon_e = exp_q.pop_front();
			`CHK(mon_n, mon_e, o_rd_data)
		end
	end
	task cyc(input int n);
		repeat (n) @(negedge i_mclk);
	endtask
	task wr(input logic [7:0] a, input logic [15:0] v);
		i_cmd = a;
		i_wr_data = v;
		i_wr_en = 1'b1;
		cyc(1);
		i_wr_en = 1'b0;
		cyc(1);
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e, input string n);
		exp_q.push_back(e);
		nm_q.push_back(n);
		i_cmd = a;
		i_rd_en = 1'b1;
		cyc(1);
		i_rd_en = 1'b0;
		cyc(1);
	endtask
	task wait_lv(input string n, input logic v, input int lim);
		int k;
		k = 0;
		while (k < lim && o_throttle_alert_n !== v) begin
			cyc(1);
			k++;
		end
		`CHK(n, v, o_throttle_alert_n)
		if (o_throttle_alert_n !== v) tally_and_finish();
	endtask
	task tally_and_finish();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		cyc(16);
		i_reset_n = 1'b1;
		cyc(2);
		`CHK("alert_rst", 1'b1, o_throttle_alert_n)
		rd(8'h32, 16'h0000, "opt_c_rst");
		rd(8'h33, 16'h4A54, "alert_a_rst");
		rd(8'h45, 16'h0000, "unmapped");
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 16'h8802 : 16'($random(seed)) & 16'h9FFF;
			wr(8'h32, d);
			rd(8'h32, d, "opt_c");
			`CHK("highz", d[15], o_ctrl.high_impedance)
			`CHK("bat_sw", !(d[15] && d[1]), o_ctrl.battery_switch_on)
			`CHK("optimizer", d[11], o_ctrl.optimizer_enable)
			d = 16'($random(seed));
			wr(8'h33, d);
			rd(8'h33, d | 16'h0004, "alert_a");
		end
		wr(8'h32, 16'h4000);
		rd(8'h32, 16'h0000, "dflt_c");
		rd(8'h33, 16'h4A54, "dflt_a");
		wr(8'h32, 16'h2000);
		`CHK("conv_off", 1'b0, o_ctrl.converter_enable)
		for (int k = 0; k < 50 && o_ctrl.converter_enable !== 1'b1; k++) cyc(1);
		`CHK("conv_on", 1'b1, o_ctrl.converter_enable)
		if (o_ctrl.converter_enable !== 1'b1) tally_and_finish();
		rd(8'h32, 16'h0000, "remeas_clr");
		foreach (codes[i]) begin
			p = (codes[i] <= 25) ? 110 + 5 * (codes[i] - 1) : 250 + 50 * (codes[i] - 26);
			wr(8'h33, 16'(codes[i] << 11) | 16'h0004);
			cur = 16'(p * 11);
			cyc(10);
			`CHK("oc_below", 1'b1, o_throttle_alert_n)
			cur = 16'(p * 11 + 1);
			wait_lv("oc_fire", 1'b0, 6);
			cur = 16'h0000;
			cyc(12);
			`CHK("pw_hold", 1'b0, o_throttle_alert_n)
			wait_lv("pw_end", 1'b1, 30);
		end
		wr(8'h33, 16'hF804);
		cur = 16'hFFFF;
		cyc(10);
		`CHK("oc_ignored", 1'b1, o_throttle_alert_n)
		cur = 16'h0000;
		wr(8'h33, 16'h4824);
		cur = 16'h0673;
		wait_lv("st_fire", 1'b0, 6);
		cur = 16'h0000;
		cyc(100);
		`CHK("st_hold", 1'b0, o_throttle_alert_n)
		wr(8'h33, 16'h4820);
		`CHK("st_clear", 1'b1, o_throttle_alert_n)
		for (int u = 0; u < 8; u++) begin
			one = u[2];
			thr = one ? 2850 + 250 * u[1:0] : 5750 + 250 * u[1:0];
			wr(8'h33, 16'h4804 | 16'({u[1:0], 6'h00}));
			mv = 16'(thr - 1);
			cyc(3950);
			`CHK("uv_filter", 1'b1, o_throttle_alert_n)
			wait_lv("uv_fire", 1'b0, 100);
			mv = 16'(thr);
			wait_lv("uv_end", 1'b1, 100);
		end
		tally_and_finish();
	end
endmodule
